// ### hw/ifv_defs.svh
// Register offsets, field positions, reset values and vector constants for the interrupt block
// Assumes inclusion by bare name from design files
`ifndef IFV_DEFS_SVH
`define IFV_DEFS_SVH
// Byte addresses are four times the printed register index
`define IFV_IDX_CTRL     8'h0B
`define IFV_IDX_PFLAG1   8'h0C
`define IFV_IDX_PFLAG2   8'h0D
`define IFV_IDX_PEN1     8'h8C
`define IFV_IDX_PEN2     8'h8D
`define IFV_IDX_STAT     8'hF0
// Control register bits
`define IFV_B_GIE        7
`define IFV_B_PERIPHERAL_GROUP_ENABLE       6
`define IFV_B_TIMER_OVERFLOW_ENABLE       5
`define IFV_B_INTE       4
`define IFV_B_RBIE       3
`define IFV_B_TIMER_OVERFLOW_FLAG       2
`define IFV_B_EXTERNAL_PIN_FLAG       1
`define IFV_B_PORT_CHANGE_FLAG       0
// Peripheral flag register one bits
`define IFV_B_PSP        7
`define IFV_B_CONV       6
`define IFV_B_PMATCH     1
// Reset values and masks
`define IFV_RST_BYTE     8'h00
`define IFV_PF1_MASK     8'hF7
`define IFV_PF2_MASK     8'h10
`define IFV_CTRL_HWF     8'h07
`define IFV_VECTOR       13'h0004
`define IFV_TMR_MAX      8'hFF
`define IFV_RESP_OKAY    2'h0
`define IFV_RESP_SLVERR  2'h2
`endif

// ### hw/ifv_pkg.sv
// Types for the interrupt flag and vector block
// Assumes nothing beyond a SystemVerilog compiler
package ifv_pkg;
  typedef enum logic [1:0] {IFV_RUN, IFV_SLEEP, IFV_ENTRY} ifv_state_t;
  typedef logic [7:0]  ifv_byte_t;
  typedef logic [12:0] ifv_pc_t;
endpackage

// ### hw/ifv_irq_ctrl.sv
// Interrupt flag, enable and vector logic of an 8-bit microcontroller, AXI4-Lite registers
// Assumes aclk is the instruction-cycle clock and event inputs are one-cycle pulses
//
// Behaviour
// - Parallel port access sets its flag; it stays until software clears it.
// - Conversion completion sets the conversion done flag; it stays until software clears it.
// - Second timer count equal to its period sets the period match flag.
// - Eight-bit timer wrap from maximum to zero sets the overflow flag.
// - Timer overflow interrupt suppressed while its enable is zero.
// - Timer overflow never wakes the processor from sleep.
// - Up to eleven sources, each with its own flag bit.
// - Flags set on events regardless of any enable.
// - Global enable passes unmasked interrupts when one, blocks all when zero.
// - Vector three cycles after the take when global enable and any flag with its enables set, group enable included for peripherals.
// - Global enable forced to zero on every reset.
// - Return-from-interrupt leaves the routine and sets global enable.
// - Pin, port change and overflow flags live in the control register.
// - Peripheral flags and enables in two registers each; group enable in control.
// - On response clear global enable, push return address, load vector.
// - External event to vector takes four instruction cycles.
// - Latency identical for one-cycle and two-cycle instructions.
// - Wake from sleep on enabled interrupt other than overflow; vector only if global enable.
// - Peripheral interrupts pass only with the group enable set.
`timescale 1ns/1ps
`include "ifv_defs.svh"

module ifv_irq_ctrl #(
  parameter int ENTRY_CYCLES = 2
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [9:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [9:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Event sources: one-cycle pulses and timer counts
  input  wire logic              ext_pin_evt,
  input  wire logic              port_change_evt,
  input  wire logic [7:0]        eight_bit_timer_count,
  input  wire logic [7:0]        second_timer_count,
  input  wire logic [7:0]        second_timer_period,
  input  wire logic              conversion_done_evt,
  input  wire logic              parallel_port_access,
  input  wire logic [6:0]        other_pf1_evt,
  input  wire logic              other_pf2_evt,
  // Processor core
  input  wire logic              core_sleeping,
  input  wire logic              return_from_isr,
  input  wire ifv_pkg::ifv_pc_t  core_pc,
  output logic                   core_wake,
  output logic                   core_vector,
  output ifv_pkg::ifv_pc_t       core_vector_addr,
  output logic                   stack_push,
  output ifv_pkg::ifv_pc_t       stack_push_addr
);
  import ifv_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Registers
  ifv_byte_t  ctrl_q, ctrl_d;
  ifv_byte_t  pf1_q, pf1_d, pf2_q, pf2_d;
  ifv_byte_t  pen1_q, pen2_q;
  ifv_byte_t  tmr_prev_q;
  ifv_state_t state_q;
  logic [1:0] entry_cnt_q;
  logic       irq_req_q;
  logic       aw_hold_q, w_hold_q;
  logic [7:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic       wstrb0_q;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite decode
  wire        wr_fire  = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire        wr_en    = wr_fire && wstrb0_q;
  wire        wr_ctrl  = wr_en && (aw_idx_q == `IFV_IDX_CTRL);
  wire        wr_pf1   = wr_en && (aw_idx_q == `IFV_IDX_PFLAG1);
  wire        wr_pf2   = wr_en && (aw_idx_q == `IFV_IDX_PFLAG2);
  wire        wr_pen1  = wr_en && (aw_idx_q == `IFV_IDX_PEN1);
  wire        wr_pen2  = wr_en && (aw_idx_q == `IFV_IDX_PEN2);
  wire        wr_hit   = (aw_idx_q == `IFV_IDX_CTRL) || (aw_idx_q == `IFV_IDX_PFLAG1) ||
                         (aw_idx_q == `IFV_IDX_PFLAG2) || (aw_idx_q == `IFV_IDX_PEN1) ||
                         (aw_idx_q == `IFV_IDX_PEN2);
  wire [7:0]  ar_idx   = s_axi_araddr[9:2];
  wire        rd_fire  = s_axi_arvalid && s_axi_arready;
  wire        rd_hit   = wr_hit_f(ar_idx) || (ar_idx == `IFV_IDX_STAT);
  wire [7:0]  stat_byte = {5'h00, irq_req_q, state_q == IFV_ENTRY, state_q == IFV_SLEEP};
  wire [7:0]  rd_byte  = (ar_idx == `IFV_IDX_CTRL)   ? ctrl_q :
                         (ar_idx == `IFV_IDX_PFLAG1) ? pf1_q  :
                         (ar_idx == `IFV_IDX_PFLAG2) ? pf2_q  :
                         (ar_idx == `IFV_IDX_PEN1)   ? pen1_q :
                         (ar_idx == `IFV_IDX_PEN2)   ? pen2_q :
                         (ar_idx == `IFV_IDX_STAT)   ? stat_byte : `IFV_RST_BYTE;

  function automatic logic wr_hit_f(input logic [7:0] idx);
    wr_hit_f = (idx == `IFV_IDX_CTRL) || (idx == `IFV_IDX_PFLAG1) ||
               (idx == `IFV_IDX_PFLAG2) || (idx == `IFV_IDX_PEN1) || (idx == `IFV_IDX_PEN2);
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Event detection
  wire t0_wrap   = (tmr_prev_q == `IFV_TMR_MAX) && (eight_bit_timer_count == `IFV_RST_BYTE);
  wire pm_evt    = second_timer_count == second_timer_period;
  wire [7:0] pf1_evt = {parallel_port_access, conversion_done_evt, other_pf1_evt[6:2],
                        pm_evt} & `IFV_PF1_MASK;
  wire [7:0] pf2_evt = {3'h0, other_pf2_evt, 4'h0};
  wire [7:0] ctl_evt = {5'h00, t0_wrap, ext_pin_evt, port_change_evt};

  // Bit 1 of the peripheral word is period match; bit 0 takes the remaining source
  wire [7:0] pf1_evt_fix = {pf1_evt[7:2], pm_evt, other_pf1_evt[0]} & `IFV_PF1_MASK;

  // Software write value, then events win over clears
  wire [7:0] ctrl_sw = wr_ctrl ? wbyte_q : ctrl_q;
  wire [7:0] pf1_sw  = wr_pf1  ? (wbyte_q & `IFV_PF1_MASK) : pf1_q;
  wire [7:0] pf2_sw  = wr_pf2  ? (wbyte_q & `IFV_PF2_MASK) : pf2_q;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Request gating
  wire [7:0] pend1   = pf1_q & pen1_q;
  wire [7:0] pend2   = pf2_q & pen2_q;
  wire       periph  = ctrl_q[`IFV_B_PERIPHERAL_GROUP_ENABLE] && (|pend1 || |pend2);
  wire       core_src = (ctrl_q[`IFV_B_TIMER_OVERFLOW_ENABLE] && ctrl_q[`IFV_B_TIMER_OVERFLOW_FLAG]) ||
                        (ctrl_q[`IFV_B_INTE] && ctrl_q[`IFV_B_EXTERNAL_PIN_FLAG]) ||
                        (ctrl_q[`IFV_B_RBIE] && ctrl_q[`IFV_B_PORT_CHANGE_FLAG]);
  wire       any_req = periph || core_src;
  // Timer overflow is not a wake source since the timer stops in sleep
  wire       wake_src = periph ||
                        (ctrl_q[`IFV_B_INTE] && ctrl_q[`IFV_B_EXTERNAL_PIN_FLAG]) ||
                        (ctrl_q[`IFV_B_RBIE] && ctrl_q[`IFV_B_PORT_CHANGE_FLAG]);
  wire       take    = ctrl_q[`IFV_B_GIE] && any_req && (state_q == IFV_RUN);
  wire       wake    = (state_q == IFV_SLEEP) && wake_src;
  wire       wake_take = wake && ctrl_q[`IFV_B_GIE];
  wire       entry_done = (state_q == IFV_ENTRY) && (entry_cnt_q == 2'(ENTRY_CYCLES - 1));

  always_comb begin
    ctrl_d = ctrl_sw | ctl_evt;
    if (take || wake_take) begin
      ctrl_d[`IFV_B_GIE] = 1'b0;
    end else if (return_from_isr) begin
      ctrl_d[`IFV_B_GIE] = 1'b1;
    end
    pf1_d = pf1_sw | pf1_evt_fix;
    pf2_d = pf2_sw | pf2_evt;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Flag and enable storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= `IFV_RST_BYTE;
      pf1_q      <= `IFV_RST_BYTE;
      pf2_q      <= `IFV_RST_BYTE;
      pen1_q     <= `IFV_RST_BYTE;
      pen2_q     <= `IFV_RST_BYTE;
      tmr_prev_q <= `IFV_RST_BYTE;
    end else begin
      ctrl_q     <= ctrl_d;
      pf1_q      <= pf1_d;
      pf2_q      <= pf2_d;
      tmr_prev_q <= eight_bit_timer_count;
      if (wr_pen1) begin
        pen1_q <= wbyte_q & `IFV_PF1_MASK;
      end
      if (wr_pen2) begin
        pen2_q <= wbyte_q & `IFV_PF2_MASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Vector sequencer; fixed entry length gives equal latency for any instruction length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q          <= IFV_RUN;
      entry_cnt_q      <= 2'h0;
      irq_req_q        <= 1'b0;
      core_vector      <= 1'b0;
      core_vector_addr <= 13'h0000;
      stack_push       <= 1'b0;
      stack_push_addr  <= 13'h0000;
      core_wake        <= 1'b0;
    end else begin
      irq_req_q   <= any_req && ctrl_q[`IFV_B_GIE];
      core_vector <= 1'b0;
      stack_push  <= 1'b0;
      core_wake   <= wake;
      case (state_q)
        // A wake pulse outranks the sleep level that the core still shows for one cycle
        IFV_RUN: begin
          if (take) begin
            state_q         <= IFV_ENTRY;
            entry_cnt_q     <= 2'h0;
            stack_push      <= 1'b1;
            stack_push_addr <= core_pc;
          end else if (core_sleeping && !core_wake) begin
            state_q <= IFV_SLEEP;
          end
        end
        IFV_SLEEP: begin
          if (wake_take) begin
            state_q         <= IFV_ENTRY;
            entry_cnt_q     <= 2'h0;
            stack_push      <= 1'b1;
            stack_push_addr <= core_pc;
          end else if (wake) begin
            state_q <= IFV_RUN;
          end
        end
        IFV_ENTRY: begin
          entry_cnt_q <= entry_cnt_q + 2'h1;
          if (entry_done) begin
            state_q          <= IFV_RUN;
            core_vector      <= 1'b1;
            core_vector_addr <= `IFV_VECTOR;
          end
        end
        default: state_q <= IFV_RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_idx_q      <= 8'h00;
      wbyte_q       <= 8'h00;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IFV_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IFV_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `IFV_RESP_OKAY : `IFV_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_hit ? `IFV_RESP_OKAY : `IFV_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_entry_start;
    take;
  endsequence
  sequence s_vector_out;
    core_vector && (core_vector_addr == `IFV_VECTOR);
  endsequence

  a_vector_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    s_entry_start |-> ##(ENTRY_CYCLES + 1) s_vector_out)
    else $error("vector not issued after fixed entry delay");
  a_gie_clear_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    take |=> !ctrl_q[`IFV_B_GIE])
    else $error("global enable not cleared on entry");
  a_push_on_take: assert property (@(posedge aclk) disable iff (!aresetn)
    take |=> stack_push && (stack_push_addr == $past(core_pc)))
    else $error("return address not pushed");
  a_return_from_isr_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (return_from_isr && !take && !wake_take) |=> ctrl_q[`IFV_B_GIE])
    else $error("return did not set global enable");
  a_no_take_gie0: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[`IFV_B_GIE] |-> !take)
    else $error("interrupt taken with global enable clear");
  a_t0_wrap_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    t0_wrap |=> ctrl_q[`IFV_B_TIMER_OVERFLOW_FLAG])
    else $error("timer wrap did not set overflow flag");
  a_event_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (parallel_port_access && wr_pf1) |=> pf1_q[`IFV_B_PSP])
    else $error("clear beat a same-cycle event");
  a_pmatch_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    pm_evt |=> pf1_q[`IFV_B_PMATCH])
    else $error("period match flag not set");
  a_periph_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q[`IFV_B_PERIPHERAL_GROUP_ENABLE] && !core_src) |-> !take)
    else $error("peripheral interrupt passed without group enable");
  a_t0_no_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    ((state_q == IFV_SLEEP) && !periph && !ctrl_q[`IFV_B_EXTERNAL_PIN_FLAG] && !ctrl_q[`IFV_B_PORT_CHANGE_FLAG])
      |=> !core_wake)
    else $error("overflow woke the processor");
  a_reset_gie: assert property (@(posedge aclk)
    !aresetn |=> !ctrl_q[`IFV_B_GIE])
    else $error("global enable not zero after reset");

  // Wake handling and flag capture
  sequence s_wake_no_gie;
    (state_q == IFV_SLEEP) && wake_src && !ctrl_q[`IFV_B_GIE];
  endsequence
  sequence s_resume_inline;
    core_wake && (state_q == IFV_RUN);
  endsequence
  a_wake_inline: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wake_no_gie |=> s_resume_inline)
    else $error("wake without global enable did not resume in line");
  a_wake_branch: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_take |=> (state_q == IFV_ENTRY) && stack_push)
    else $error("wake with global enable did not enter the routine");
  a_wake_gie_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_take |=> !ctrl_q[`IFV_B_GIE])
    else $error("global enable not cleared on wake entry");
  a_vector_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    core_vector |=> !core_vector)
    else $error("vector pulse longer than one cycle");
  a_entry_single: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == IFV_ENTRY) |=> !stack_push)
    else $error("second push during entry");
  a_conv_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    conversion_done_evt |=> pf1_q[`IFV_B_CONV])
    else $error("conversion done flag not set");
  a_psp_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    parallel_port_access |=> pf1_q[`IFV_B_PSP])
    else $error("parallel port flag not set");
  a_psp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (pf1_q[`IFV_B_PSP] && !wr_pf1) |=> pf1_q[`IFV_B_PSP])
    else $error("parallel port flag dropped without a write");
  a_pin_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_pin_evt |=> ctrl_q[`IFV_B_EXTERNAL_PIN_FLAG])
    else $error("pin flag not set");
  a_port_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    port_change_evt |=> ctrl_q[`IFV_B_PORT_CHANGE_FLAG])
    else $error("port change flag not set");
  a_t0_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q[`IFV_B_TIMER_OVERFLOW_ENABLE] && !periph && !ctrl_q[`IFV_B_EXTERNAL_PIN_FLAG] && !ctrl_q[`IFV_B_PORT_CHANGE_FLAG]) |-> !take)
    else $error("masked overflow was taken");
endmodule

// ### bench/ifv_core_model.sv
// Behavioural processor core facing the interrupt block
// Assumes the bench pulses sleep_req and ret_req for one aclk cycle
`timescale 1ns/1ps
module ifv_core_model (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // From the interrupt block
  input  wire logic             core_vector,
  input  wire ifv_pkg::ifv_pc_t core_vector_addr,
  input  wire logic             core_wake,
  // Bench commands
  input  wire logic             sleep_req,
  input  wire logic             ret_req,
  // To the interrupt block
  output ifv_pkg::ifv_pc_t      core_pc,
  output logic                  core_sleeping,
  output logic                  return_from_isr
);
  import ifv_pkg::*;
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_pc         <= 13'h0100;
      core_sleeping   <= 1'b0;
      return_from_isr <= 1'b0;
    end else begin
      return_from_isr <= ret_req;
      if (core_vector) begin
        core_pc <= core_vector_addr;
      end else if (!core_sleeping) begin
        core_pc <= core_pc + 13'h0001;
      end
      if (core_wake) begin
        core_sleeping <= 1'b0;
      end else if (sleep_req) begin
        core_sleeping <= 1'b1;
      end
    end
  end
endmodule

// ### bench/ifv_irq_ctrl_tb.sv
// Self-checking bench for the interrupt flag and vector block
// Assumes the design, package and defines header are compiled first
`timescale 1ns/1ps
`include "ifv_defs.svh"
module ifv_irq_ctrl_tb;
  import ifv_pkg::*;
  localparam logic [9:0] A_CTRL = 10'h02C, A_PF1 = 10'h030, A_PF2 = 10'h034;
  localparam logic [9:0] A_EN1 = 10'h230, A_EN2 = 10'h234, A_BAD = 10'h100, A_STAT = 10'h3C0;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, core_wake, core_vector, stack_push;
  logic [1:0] bresp, rresp;
  logic [4:0] evt = 5'h00;
  logic [7:0] t0 = 8'h10, st_cnt = 8'h00, st_per = 8'h01, lfsr = 8'h1E;
  logic sleep_req = 0, ret_req = 0, core_sleeping, return_from_isr;
  ifv_pc_t core_pc, core_vector_addr, stack_push_addr, pc_prev;
  int error_cnt = 0, n_checks = 0, vec_cnt = 0, push_cnt = 0, wake_cnt = 0, ctrl_m, pf1_m;
  always #50 aclk = ~aclk;
  ifv_irq_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_pin_evt(evt[0]), .port_change_evt(evt[1]), .eight_bit_timer_count(t0),
    .second_timer_count(st_cnt), .second_timer_period(st_per),
    .conversion_done_evt(evt[2]), .parallel_port_access(evt[3]), .other_pf1_evt(7'h00),
    .other_pf2_evt(evt[4]), .core_sleeping(core_sleeping), .return_from_isr(return_from_isr),
    .core_pc(core_pc), .core_wake(core_wake), .core_vector(core_vector),
    .core_vector_addr(core_vector_addr), .stack_push(stack_push),
    .stack_push_addr(stack_push_addr));
  ifv_core_model u_core (.aclk(aclk), .aresetn(aresetn), .core_vector(core_vector),
    .core_vector_addr(core_vector_addr), .core_wake(core_wake), .sleep_req(sleep_req),
    .ret_req(ret_req), .core_pc(core_pc), .core_sleeping(core_sleeping),
    .return_from_isr(return_from_isr));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk(bvalid, 1'b1);
    chk(bresp, er);
  endtask
  task automatic axr(input logic [9:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    chk(rvalid, 1'b1);
    chk(rresp, er);
    chk(rdata, {24'h0, ed});
  endtask
  task automatic pulse(input int k);
    @(posedge aclk); evt[k] <= 1'b1;
    @(posedge aclk); evt[k] <= 1'b0;
  endtask
  task automatic t0_wrap();
    @(posedge aclk); t0 <= 8'hFF;
    @(posedge aclk); t0 <= 8'h00;
    @(posedge aclk); t0 <= 8'h10;
  endtask
  task automatic wait_cnt(input bit wake, input int n);
    repeat (12) @(posedge aclk);
    chk(wake ? wake_cnt : vec_cnt, n);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (aresetn) begin
      if (core_vector) begin
        vec_cnt++;
        chk(core_vector_addr, `IFV_VECTOR);
      end
      if (stack_push) begin
        push_cnt++;
        chk(stack_push_addr, pc_prev);
      end
      if (core_wake) wake_cnt++;
    end
    pc_prev = core_pc;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(A_CTRL, 8'h00, 2'h0);
    axr(A_PF1, 8'h00, 2'h0);
    axr(A_EN1, 8'h00, 2'h0);
    axr(A_STAT, 8'h00, 2'h0);
    axr(A_BAD, 8'h00, 2'h2);
    axw(A_BAD, 8'hFF, 2'h2);
    $display("test reset and map done");
    // Pin, port, conversion, parallel port, second-register, overflow and period match sources fire with all enables off
    for (int k = 0; k < 5; k++) pulse(k);
    t0_wrap();
    @(posedge aclk); st_cnt <= st_per;
    @(posedge aclk); st_cnt <= st_per + 8'h01;
    ctrl_m = 'h07;
    pf1_m = 'hC2;
    axr(A_CTRL, ctrl_m[7:0], 2'h0);
    axr(A_PF1, pf1_m[7:0], 2'h0);
    axr(A_PF2, 8'h10, 2'h0);
    chk(vec_cnt, 0);
    axr(A_PF1, pf1_m[7:0], 2'h0);
    axw(A_CTRL, 8'h00, 2'h0);
    axw(A_PF1, 8'h00, 2'h0);
    axw(A_PF2, 8'h00, 2'h0);
    axr(A_PF1, 8'h00, 2'h0);
    // Parallel port access lands on the edge at which the clear is written
    fork
      axw(A_PF1, 8'h00, 2'h0);
      begin
        repeat (3) @(posedge aclk);
        evt[3] <= 1'b1;
        @(posedge aclk);
        evt[3] <= 1'b0;
      end
    join
    axr(A_PF1, 8'h80, 2'h0);
    axw(A_PF1, 8'h00, 2'h0);
    $display("test flags done");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      st_per <= lfsr;
      axw(A_EN1, lfsr, 2'h0);
      axr(A_EN1, lfsr & `IFV_PF1_MASK, 2'h0);
      axw(A_EN2, lfsr, 2'h0);
      axr(A_EN2, lfsr & `IFV_PF2_MASK, 2'h0);
    end
    axw(A_EN1, 8'h00, 2'h0);
    $display("test enables done");
    // Overflow masked, then taken, then return
    axw(A_CTRL, 8'h80, 2'h0);
    t0_wrap();
    wait_cnt(1'b0, 0);
    axw(A_CTRL, 8'h00, 2'h0);
    axw(A_CTRL, 8'hA0, 2'h0);
    t0_wrap();
    wait_cnt(1'b0, 1);
    axr(A_CTRL, 8'h24, 2'h0);
    axw(A_CTRL, 8'h20, 2'h0);
    @(posedge aclk); ret_req <= 1'b1;
    @(posedge aclk); ret_req <= 1'b0;
    axr(A_CTRL, 8'hA0, 2'h0);
    chk(push_cnt, 1);
    $display("test overflow entry done");
    // Peripheral needs the group enable
    axw(A_EN1, 8'h40, 2'h0);
    axw(A_CTRL, 8'h80, 2'h0);
    pulse(2);
    wait_cnt(1'b0, 1);
    axw(A_CTRL, 8'hC0, 2'h0);
    wait_cnt(1'b0, 2);
    axr(A_CTRL, 8'h40, 2'h0);
    axw(A_PF1, 8'h00, 2'h0);
    axw(A_CTRL, 8'h00, 2'h0);
    $display("test group enable done");
    // Sleep: overflow never wakes, pin wakes without vector
    axw(A_CTRL, 8'h30, 2'h0);
    @(posedge aclk); sleep_req <= 1'b1;
    @(posedge aclk); sleep_req <= 1'b0;
    t0_wrap();
    wait_cnt(1'b1, 0);
    pulse(0);
    wait_cnt(1'b1, 1);
    repeat (4) @(posedge aclk);
    chk(vec_cnt, 2);
    $display("test sleep done");
    results();
  end
endmodule
